// file: hw/los_eq_pkg.sv
// Package: register map, field layouts, reset values and timing counts of one slicer channel
package los_eq_pkg;
    // ************************************************************
    // Register offsets of channel 0; channel n adds n * CHAN_STRIDE
    // ************************************************************
    localparam logic [11:0] CHAN_STRIDE = 12'h100;
    localparam logic [11:0] CHAN_BASE = 12'h0F8;
    localparam logic [7:0] OFF_CFG_STATUS = 8'hF8;
    localparam logic [7:0] OFF_THRESHOLDS = 8'hF9;
    localparam logic [7:0] OFF_DET_PERIOD = 8'hFA;
    localparam logic [7:0] OFF_CLR_PERIOD = 8'hFB;
    localparam logic [7:0] OFF_EQ_RAM_INDEX = 8'hFC;
    localparam logic [7:0] OFF_EQ_DIR = 8'hFD;
    localparam logic [7:0] OFF_EQ_LOC = 8'hFE;
    localparam logic [7:0] OFF_EQ_CFG = 8'hFF;
    localparam logic [7:0] OFF_EQ_DATA0 = 8'hD8;
    localparam logic [7:0] OFF_EQ_DATA3 = 8'hDB;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_CHANGE_FLAG = 7;
    localparam int BIT_LOSS_STATE = 6;
    localparam int BIT_IRQ_EN = 5;
    localparam int BIT_MUTE_EN = 4;
    localparam int BIT_QTEST_EN = 3;
    localparam int BIT_SETTLED = 2;
    localparam int BIT_CFG_RSVD = 0;
    localparam int POS_CLR_CODE = 4;
    localparam int POS_DET_CODE = 0;
    localparam int BIT_READ_NOT_WRITE = 7;
    localparam int POS_VALID_PER = 6;
    localparam int BIT_EQ_RSVD = 3;
    localparam int POS_LOOP_RATE = 0;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_MUTE_EN = 1'b0;
    localparam logic RST_QTEST_EN = 1'b0;
    localparam logic RST_CFG_RSVD = 1'b1;
    localparam logic [2:0] RST_LEVEL_CODE = 3'h0;
    localparam logic [7:0] RST_DURATION = 8'h01;
    localparam logic [7:0] RST_EQ_INDEX = 8'h00;
    localparam logic RST_READ_NOT_WRITE = 1'b1;
    localparam logic [7:0] RST_LOCATION = 8'h00;
    localparam logic [1:0] RST_VALID_PER = 2'h0;
    localparam logic RST_EQ_RSVD = 1'b0;
    localparam logic [2:0] RST_LOOP_RATE = 3'h3;
    // ************************************************************
    // Counts
    // ************************************************************
    localparam int DURATION_SCALE_LOG2 = 4;
    localparam logic [7:0] SETTLE_WINDOW = 8'h08;
    localparam int VALID_BASE_LOG2 = 5;
    localparam int T1_RATE_KHZ = 1544;
    localparam int T1_LOOP_KHZ_X1000 = 24125;
endpackage

// file: hw/eq_ram_if.sv
// Interface: indirect access port between the register file and the equalizer RAM
`timescale 1ns/1ns
interface eq_ram_if;
    logic req;
    logic read_not_write;
    logic [7:0] index;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    modport master (output req, output read_not_write, output index, output wdata,
        input rdata, input done);
    modport slave (input req, input read_not_write, input index, input wdata,
        output rdata, output done);
endinterface

// file: hw/eq_ram.sv
// Equalizer RAM: 256 words of flip-flops with a one-cycle indirect access port
`timescale 1ns/1ns
module eq_ram #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    eq_ram_if.slave port,
    input wire logic [7:0] loop_index,
    output logic [WIDTH-1:0] loop_word
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    // ************************************************************
    // Storage; contents are not reset, like the rest of the table
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (port.req && !port.read_not_write) begin
            mem_r[port.index] <= port.wdata;
        end
    end
    // Read data and completion pulse one cycle after the request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port.done <= 1'b0;
            port.rdata <= '0;
        end else begin
            port.done <= port.req;
            if (port.req && port.read_not_write) begin
                port.rdata <= mem_r[port.index];
            end
        end
    end
    // Loop path reads at the location counter
    assign loop_word = mem_r[loop_index];
endmodule

// file: hw/los_eq_ctrl.sv
// Top: loss-of-signal detection, data mute and equalizer control of one slicer channel
// Function
// - Each of four channels has its own register set, 0x100 apart from 0F8H.
// - Settled flag rises when loss estimate stays within +/-8 steps long enough.
// - Either quiescent test bit forces analog receiver digital outputs to ground.
// - Mute enable forces recovered data to zero while loss of signal holds.
// - Interrupt enable drives irq_out_n low on loss state change.
// - Loss state bit reads zero when long-haul operation is selected.
// - Change flag sets on every change of the reported loss state bit, clears on status read.
// - Three-bit code picks level 9..35 dB, shared by detect and clear.
// - Declare loss after level at or below threshold 16*period pulses.
// - Clear loss after level at or above threshold 16*period pulses.
// - Period field times sixteen gives duration; both periods reset to one.
// - Writing indirect address starts RAM access through data registers D8H-DBH.
// - Direction bit: 1 reads, 0 writes; resets to 1.
// - Location write overwrites RAM read counter; read returns its value.
// - Three-bit loop rate sets equalizer loop frequency; resets to 011.
// - Valid period selects 32, 64, 128 or 256 stable loop periods.
// - Unused bits ignore writes; software masks them on read.
// - Writable bits without documented reset value stay uninitialised.
`timescale 1ns/1ns
module los_eq_ctrl
    import los_eq_pkg::*;
#(
    parameter logic [1:0] CHANNEL = 2'h0,
    parameter int LOOP_DIV = 64
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [11:0] addr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic irq_out_n,
    input wire logic long_haul_select,
    input wire logic chip_quiescent_test_bit,
    input wire logic [2:0] level_code_in,
    input wire logic [7:0] cable_loss_estimate,
    input wire logic rx_data_in,
    output logic rx_data_out,
    output logic analog_out_ground,
    output logic [2:0] detect_level_code,
    output logic [2:0] clear_level_code,
    output logic [2:0] eq_loop_rate,
    output logic [31:0] eq_loop_word,
    output logic [7:0] eq_location
);
    import los_eq_pkg::*;
    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic rst_meta_r, rst_n;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end
    logic [23:0] pin_meta_r, pin_sync_r;
    logic [2:0] lvl_meta_r, lvl_sync_r;
    // Address, data and strobes share one pipeline, so they settle in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 24'h00000E;
            pin_sync_r <= 24'h00000E;
            lvl_meta_r <= 3'h0;
            lvl_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {addr, wdata, rd_n, wr_n, cs_n, long_haul_select};
            pin_sync_r <= pin_meta_r;
            lvl_meta_r <= level_code_in;
            lvl_sync_r <= lvl_meta_r;
        end
    end
    logic rd_n_s, wr_n_s, cs_n_s, long_s;
    logic [11:0] addr_s;
    logic [7:0] wdata_s, off;
    assign {addr_s, wdata_s, rd_n_s, wr_n_s, cs_n_s, long_s} = pin_sync_r;
    // ************************************************************
    // Bus decode: access taken on the strobe's falling edge
    // ************************************************************
    logic rd_d_r, wr_d_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_d_r <= 1'b0;
            wr_d_r <= 1'b0;
        end else begin
            rd_d_r <= !cs_n_s && !rd_n_s;
            wr_d_r <= !cs_n_s && !wr_n_s;
        end
    end
    logic chan_hit;
    logic wr_stb, rd_stb;
    assign chan_hit = (addr_s[9:8] == CHANNEL) && (addr_s[11:10] == 2'h0);
    assign wr_stb = !cs_n_s && !wr_n_s && !wr_d_r && chan_hit;
    assign rd_stb = !cs_n_s && !rd_n_s && !rd_d_r && chan_hit;
    assign off = addr_s[7:0];

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic irq_en_r, mute_en_r, qtest_en_r, cfg_rsvd_r;
    logic [2:0] det_code_r, clr_code_r;
    logic [7:0] det_dur_r, clr_dur_r;
    logic [7:0] eq_index_r;
    logic rnw_r;
    logic [1:0] valid_per_r;
    logic eq_rsvd_r;
    logic [2:0] loop_rate_r;
    // Only bits with a reset value are reset; unused bits are not stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_r <= RST_IRQ_EN;
            mute_en_r <= RST_MUTE_EN;
            qtest_en_r <= RST_QTEST_EN;
            cfg_rsvd_r <= RST_CFG_RSVD;
            det_code_r <= RST_LEVEL_CODE;
            clr_code_r <= RST_LEVEL_CODE;
            det_dur_r <= RST_DURATION;
            clr_dur_r <= RST_DURATION;
            eq_index_r <= RST_EQ_INDEX;
            rnw_r <= RST_READ_NOT_WRITE;
            valid_per_r <= RST_VALID_PER;
            eq_rsvd_r <= RST_EQ_RSVD;
            loop_rate_r <= RST_LOOP_RATE;
        end else if (wr_stb) begin
            case (off)
                OFF_CFG_STATUS: begin
                    irq_en_r <= wdata_s[BIT_IRQ_EN];
                    mute_en_r <= wdata_s[BIT_MUTE_EN];
                    qtest_en_r <= wdata_s[BIT_QTEST_EN];
                    cfg_rsvd_r <= wdata_s[BIT_CFG_RSVD];
                end
                OFF_THRESHOLDS: begin
                    clr_code_r <= wdata_s[POS_CLR_CODE +: 3];
                    det_code_r <= wdata_s[POS_DET_CODE +: 3];
                end
                OFF_DET_PERIOD: det_dur_r <= wdata_s;
                OFF_CLR_PERIOD: clr_dur_r <= wdata_s;
                OFF_EQ_RAM_INDEX: eq_index_r <= wdata_s;
                OFF_EQ_DIR: rnw_r <= wdata_s[BIT_READ_NOT_WRITE];
                OFF_EQ_CFG: begin
                    valid_per_r <= wdata_s[POS_VALID_PER +: 2];
                    eq_rsvd_r <= wdata_s[BIT_EQ_RSVD];
                    loop_rate_r <= wdata_s[POS_LOOP_RATE +: 3];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Loss-of-signal detection: code compare against measured level
    // ************************************************************
    logic loss_r;
    logic [11:0] det_cnt_r, clr_cnt_r;
    logic below, above;
    // Larger code means weaker signal; equal counts on both sides
    assign below = lvl_sync_r >= det_code_r;
    assign above = lvl_sync_r <= clr_code_r;
    // One sys_clk stands for one pulse interval
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_r <= 1'b0;
            det_cnt_r <= 12'h000;
            clr_cnt_r <= 12'h000;
        end else if (!loss_r) begin
            clr_cnt_r <= 12'h000;
            if (!below) begin
                det_cnt_r <= 12'h000;
            end else if (det_cnt_r + 12'h001 >= {det_dur_r, 4'h0}) begin
                loss_r <= 1'b1;
                det_cnt_r <= 12'h000;
            end else begin
                det_cnt_r <= det_cnt_r + 12'h001;
            end
        end else begin
            det_cnt_r <= 12'h000;
            if (!above) begin
                clr_cnt_r <= 12'h000;
            end else if (clr_cnt_r + 12'h001 >= {clr_dur_r, 4'h0}) begin
                loss_r <= 1'b0;
                clr_cnt_r <= 12'h000;
            end else begin
                clr_cnt_r <= clr_cnt_r + 12'h001;
            end
        end
    end

    // Reported state forced low in long haul; the flag follows the report
    logic state_bit, state_d_r, flag_r;
    assign state_bit = loss_r && !long_s;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_d_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            state_d_r <= state_bit;
            if (state_bit != state_d_r) begin
                flag_r <= 1'b1;
            end else if (rd_stb && off == OFF_CFG_STATUS) begin
                flag_r <= 1'b0;
            end
        end
    end
    // Interrupt and datapath outputs, all registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_n <= 1'b1;
            rx_data_out <= 1'b0;
            analog_out_ground <= 1'b0;
        end else begin
            irq_out_n <= !(flag_r && irq_en_r);
            rx_data_out <= rx_data_in && !(mute_en_r && loss_r);
            analog_out_ground <= qtest_en_r || chip_quiescent_test_bit;
        end
    end

    // ************************************************************
    // Equalizer RAM access and location counter
    // ************************************************************
    eq_ram_if ram_port ();
    logic [31:0] ind_data_r;
    logic req_r;
    logic [7:0] loc_r;
    logic [31:0] loop_word;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r <= 1'b0;
        end else begin
            req_r <= wr_stb && off == OFF_EQ_RAM_INDEX;
        end
    end
    assign ram_port.req = req_r;
    assign ram_port.read_not_write = rnw_r;
    assign ram_port.index = eq_index_r;
    assign ram_port.wdata = ind_data_r;
    // Indirect data bytes, refilled by a completed read
    always_ff @(posedge sys_clk) begin
        if (ram_port.done && rnw_r) begin
            ind_data_r <= ram_port.rdata;
        end else if (wr_stb && off >= OFF_EQ_DATA0 && off <= OFF_EQ_DATA3) begin
            ind_data_r[8*off[1:0] +: 8] <= wdata_s;
        end
    end
    // Loop tick every LOOP_DIV*(code+1) cycles; >= so a lowered code cannot strand it
    logic [9:0] tick_cnt_r;
    logic tick;
    assign tick = tick_cnt_r >= 10'(LOOP_DIV * (32'(loop_rate_r) + 1) - 1);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 10'h000;
            loc_r <= RST_LOCATION;
        end else begin
            tick_cnt_r <= tick ? 10'h000 : tick_cnt_r + 10'h001;
            if (wr_stb && off == OFF_EQ_LOC) begin
                loc_r <= wdata_s;
            end else if (tick) begin
                loc_r <= loc_r + 8'h01;
            end
        end
    end
    eq_ram #(.DEPTH(256), .WIDTH(32)) u_ram (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(ram_port),
        .loop_index(loc_r),
        .loop_word(loop_word)
    );

    // ************************************************************
    // Settled flag: loss estimate within window for N loop periods
    // ************************************************************
    logic [7:0] ref_r;
    logic [8:0] stable_cnt_r;
    logic settled_r;
    logic [8:0] need;
    logic [7:0] diff;
    assign need = 9'(32'(1) << (VALID_BASE_LOG2 + 32'(valid_per_r)));
    assign diff = cable_loss_estimate >= ref_r ? cable_loss_estimate - ref_r :
        ref_r - cable_loss_estimate;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_r <= 8'h00;
            stable_cnt_r <= 9'h000;
            settled_r <= 1'b0;
        end else if (tick) begin
            if (diff > SETTLE_WINDOW) begin
                ref_r <= cable_loss_estimate;
                stable_cnt_r <= 9'h000;
                settled_r <= 1'b0;
            end else if (stable_cnt_r >= need) begin
                settled_r <= 1'b1;
            end else begin
                stable_cnt_r <= stable_cnt_r + 9'h001;
            end
        end
    end
    // Copies of steering fields for the analog side
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_level_code <= RST_LEVEL_CODE;
            clear_level_code <= RST_LEVEL_CODE;
            eq_loop_rate <= RST_LOOP_RATE;
            eq_loop_word <= 32'h0000_0000;
            eq_location <= RST_LOCATION;
        end else begin
            detect_level_code <= det_code_r;
            clear_level_code <= clr_code_r;
            eq_loop_rate <= loop_rate_r;
            eq_loop_word <= loop_word;
            eq_location <= loc_r;
        end
    end

    // ************************************************************
    // Read data; unused bits read as zero
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            case (off)
                OFF_CFG_STATUS: rdata <= {flag_r, state_bit, irq_en_r, mute_en_r,
                    qtest_en_r, settled_r, 1'b0, cfg_rsvd_r};
                OFF_THRESHOLDS: rdata <= {1'b0, clr_code_r, 1'b0, det_code_r};
                OFF_DET_PERIOD: rdata <= det_dur_r;
                OFF_CLR_PERIOD: rdata <= clr_dur_r;
                OFF_EQ_RAM_INDEX: rdata <= eq_index_r;
                OFF_EQ_DIR: rdata <= {rnw_r, 7'h00};
                OFF_EQ_LOC: rdata <= loc_r;
                OFF_EQ_CFG: rdata <= {valid_per_r, 2'h0, eq_rsvd_r, loop_rate_r};
                default: rdata <= (off >= OFF_EQ_DATA0 && off <= OFF_EQ_DATA3) ?
                    ind_data_r[8*off[1:0] +: 8] : 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    mute_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mute_en_r && loss_r) |=> !rx_data_out) else $error("mute failed");
    long_haul_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_stb && long_s && off == OFF_CFG_STATUS) |=> !rdata[BIT_LOSS_STATE])
        else $error("state shown in long haul");
    flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_bit != state_d_r) |=> flag_r) else $error("change flag missed");
    irq_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !irq_en_r |=> irq_out_n) else $error("irq while disabled");
    ground_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chip_quiescent_test_bit |=> analog_out_ground) else $error("ground missed");
    det_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!loss_r && !below) |=> det_cnt_r == 12'h000) else $error("no restart");
    ram_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_stb && off == OFF_EQ_RAM_INDEX) |=> req_r ##1 ram_port.done)
        else $error("ram access not started");
    loss_when_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(loss_r) |-> $past(det_cnt_r) + 12'h001 >= {$past(det_dur_r), 4'h0})
        else $error("loss declared early");
endmodule

// file: test/host_bus_model.sv
// Host microprocessor model that drives the 8-bit register port
`timescale 1ns/1ns
module host_bus_model (
    input wire logic sys_clk,
    output logic [11:0] addr,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    // Idle bus with all strobes high
    initial begin
        addr = 12'hFFF;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = 8'h00;
    end
    // ****************************************
    // One access: strobe low 4 cycles, high 4
    // ****************************************
    // Gap after release keeps the strobe-high time above three cycles
    task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge sys_clk);
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (4) @(negedge sys_clk);
        q = rdata;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = ~d; // Released data lines show the inverse, never a stale copy
        addr = ~a;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

// file: test/tb_los_eq_ctrl.sv
// Testbench for one slicer channel: register port, loss detection, mute and equalizer
`timescale 1ns/1ns
module tb_los_eq_ctrl;
    import los_eq_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] addr;
    logic cs_n, rd_n, wr_n, irq_out_n, rx_data_out, analog_out_ground;
    logic [7:0] wdata, rdata, q, eq_location;
    logic long_haul_select = 1'b0;
    logic chip_quiescent_test_bit = 1'b0;
    logic rx_data_in = 1'b1;
    logic [2:0] level_code_in = 3'h0;
    logic [2:0] detect_level_code, clear_level_code, eq_loop_rate;
    logic [31:0] eq_loop_word;
    logic [7:0] cable_loss_estimate = 8'h40;
    int error_cnt = 0;
    int compares = 0;
    always #2 sys_clk = ~sys_clk;
    // Short loop divider keeps the settle window to a few hundred cycles
    los_eq_ctrl #(.CHANNEL(2'h0), .LOOP_DIV(4)) los_eq_ctrl_inst (.sys_clk(sys_clk),
        .rstn(rstn), .addr(addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata),
        .rdata(rdata), .irq_out_n(irq_out_n), .long_haul_select(long_haul_select),
        .chip_quiescent_test_bit(chip_quiescent_test_bit), .level_code_in(level_code_in),
        .cable_loss_estimate(cable_loss_estimate), .rx_data_in(rx_data_in),
        .rx_data_out(rx_data_out), .analog_out_ground(analog_out_ground),
        .detect_level_code(detect_level_code), .clear_level_code(clear_level_code),
        .eq_loop_rate(eq_loop_rate), .eq_loop_word(eq_loop_word), .eq_location(eq_location));
    host_bus_model host_bus_model_inst (.sys_clk(sys_clk), .addr(addr), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata));
    // ****************************************
    // Access, compare and verdict helpers
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host_bus_model_inst.acc(1'b1, a, d, dummy);
    endtask
    task automatic rd(input logic [11:0] a);
        host_bus_model_inst.acc(1'b0, a, 8'h00, q);
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog: whole sequence needs well under 10000 cycles
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(12'h0F8); chk("cfg_rst", q & 8'h39, 8'h01);
        rd(12'h0FA); chk("detect_duration_rst", q, 8'h01);
        rd(12'h0FB); chk("clear_duration_rst", q, 8'h01);
        rd(12'h0FD); chk("dir_rst", q[7], 1'b1);
        rd(12'h0FF); chk("eq_cfg_rst", q & 8'h0F, 8'h03);
        chk("loop_rate", eq_loop_rate, 3'h3);
        rd(12'h0F0); chk("unmapped", q, 8'h00);
        // Every level code in both fields, always kept equal
        for (int c = 0; c < 8; c++) begin
            wr(12'h0F9, {1'b0, c[2:0], 1'b0, c[2:0]});
            rd(12'h0F9); chk("thr", q & 8'h77, {1'b0, c[2:0], 1'b0, c[2:0]});
        end
        wr(12'h0F9, 8'h33);
        wr(12'h1F9, 8'h55);
        rd(12'h0F9); chk("chan_iso", q & 8'h77, 8'h33);
        chk("det_code", detect_level_code, 3'h3);
        chk("clr_code", clear_level_code, 3'h3);
        wr(12'h0FF, 8'h08);
        chk("loop_rate0", eq_loop_rate, 3'h0);
        // Code 0 counts every level as weak, so loss moved after reset: drop that flag
        rd(12'h0F8); chk("loss_idle", q[6], 1'b0);
        wr(12'h0F8, 8'h21);
        // Weak level broken by a short dip must restart the count
        level_code_in = 3'h5;
        repeat (12) @(negedge sys_clk);
        level_code_in = 3'h1;
        repeat (2) @(negedge sys_clk);
        level_code_in = 3'h5;
        repeat (12) @(negedge sys_clk);
        chk("irq_early", irq_out_n, 1'b1);
        repeat (12) @(negedge sys_clk);
        chk("irq_low", irq_out_n, 1'b0);
        rd(12'h0F8); chk("loss_set", q[7:6], 2'b11);
        chk("irq_clr", irq_out_n, 1'b1);
        rd(12'h0F8); chk("flag_cor", q[7], 1'b0);
        chk("no_mute", rx_data_out, 1'b1);
        wr(12'h0F8, 8'h31);
        chk("muted", rx_data_out, 1'b0);
        long_haul_select = 1'b1;
        rd(12'h0F8); chk("long_haul", q[6], 1'b0);
        long_haul_select = 1'b0;
        level_code_in = 3'h1;
        repeat (30) @(negedge sys_clk);
        rd(12'h0F8); chk("loss_clr", q[7:6], 2'b10);
        chk("unmuted", rx_data_out, 1'b1);
        rx_data_in = 1'b0;
        @(negedge sys_clk);
        chk("pass_zero", rx_data_out, 1'b0);
        rx_data_in = 1'b1;
        chip_quiescent_test_bit = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("gnd_chip", analog_out_ground, 1'b1);
        chip_quiescent_test_bit = 1'b0;
        wr(12'h0F8, 8'h09);
        chk("gnd_local", analog_out_ground, 1'b1);
        wr(12'h0F8, 8'h01);
        chk("gnd_off", analog_out_ground, 1'b0);
        repeat (300) @(negedge sys_clk);
        rd(12'h0F8); chk("settled", q[2], 1'b1);
        cable_loss_estimate = 8'h54;
        repeat (20) @(negedge sys_clk);
        rd(12'h0F8); chk("unsettled", q[2], 1'b0);
        // Indirect write, scrub the data registers, then read back
        for (int i = 0; i < 4; i++) wr(12'h0D8 + 12'(i), 8'(8'h11 * (i + 1)));
        wr(12'h0FD, 8'h00);
        wr(12'h0FC, 8'h05);
        for (int i = 0; i < 4; i++) wr(12'h0D8 + 12'(i), 8'h00);
        wr(12'h0FD, 8'h80);
        wr(12'h0FC, 8'h05);
        for (int i = 0; i < 4; i++) begin
            rd(12'h0D8 + 12'(i)); chk("ram_rd", q, 8'(8'h11 * (i + 1)));
        end
        // Loop ticks every 4 cycles at rate code 0: one tick in the 4 edges after a write
        wr(12'h0FE, 8'h04);
        chk("loc_out", eq_location, 8'h05);
        chk("loop_word", eq_loop_word, 32'h4433_2211);
        // Eight edges lie between the write and the read sample: exactly two ticks
        wr(12'h0FE, 8'h05);
        rd(12'h0FE); chk("location", q, 8'h07);
        give_verdict();
    end
endmodule
